// ==== dac_word_loader.sv ====
// Converter end: serial shift register and converter latch
// Operation
// - Latch resets to zero until loaded
// - Shift register not cleared by reset
// - Long frame keeps last sixteen bits
// - Short frame keeps older unshifted bits
// - Host sends sixteen bits first load
// - Host pads short data with zero LSBs
// - Sixteen-bit word, sampled rising clock edge
// - Latch update at frame end or pin
// - Link is clock, data, select, update
// - Host makes clock, low frame, words
// - Bipolar latch code is offset binary
// - Shift MSB first only while selected
// - Select rise after sixteen bits loads if update pin low
// - Update pin low after select loads
`timescale 1ns/1ps
module dac_word_loader #(
  parameter int WORD_W = dac_link_pkg::WORD_BITS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  dac_link_if.converter link,
  output logic [WORD_W-1:0] dac_code,
  output logic bipolar_neg,
  output logic [WORD_W-1:0] bipolar_mag,
  output logic load_pulse
);
  typedef struct packed {
    logic [2:0] sclk_s;
    logic [1:0] sdata_s;
    logic [2:0] sel_s;
    logic [2:0] upd_s;
    logic [WORD_W-1:0] shift;
    logic [dac_link_pkg::BIT_CNT_W-1:0] cnt;
    logic pending;
    logic [WORD_W-1:0] latch;
    logic neg;
    logic [WORD_W-1:0] mag;
    logic load;
  } conv_state_t;

  // Current and next copy of the whole state
  conv_state_t st_r, st_nxt;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Push a pin sample into a three-stage sync chain
  function automatic logic [2:0] sync_push(input logic [2:0] stages, input logic pin);
    logic [2:0] pushed;
    pushed = {stages[1:0], pin};
    return pushed;
  endfunction

  // Rising edge between the last two sync stages
  function automatic logic rose_at(input logic [2:0] stages);
    logic seen;
    seen = stages[1] & ~stages[2];
    return seen;
  endfunction

  // Level after the second sync stage
  function automatic logic level_at(input logic [2:0] stages);
    logic seen;
    seen = stages[1];
    return seen;
  endfunction

  // Enough bits since the last load for a whole word
  function automatic logic word_full(input logic [dac_link_pkg::BIT_CNT_W-1:0] cnt);
    logic full;
    full = (cnt == dac_link_pkg::WORD_BITS_CNT);
    return full;
  endfunction

  // Saturating bit count toward a full word
  function automatic logic [dac_link_pkg::BIT_CNT_W-1:0] count_step(
    input logic [dac_link_pkg::BIT_CNT_W-1:0] cnt
  );
    logic [dac_link_pkg::BIT_CNT_W-1:0] next_cnt;
    next_cnt = cnt;
    if (!word_full(cnt)) begin
      next_cnt = cnt + 1'b1;
    end
    return next_cnt;
  endfunction

  // One bit in at the low end, oldest bit leaves at the top
  function automatic logic [WORD_W-1:0] shift_in(
    input logic [WORD_W-1:0] word,
    input logic bit_in
  );
    logic [WORD_W-1:0] shifted;
    shifted = {word[WORD_W-2:0], bit_in};
    return shifted;
  endfunction

  // Offset-binary sign: below midscale is negative
  function automatic logic offset_neg(input logic [WORD_W-1:0] code);
    logic neg;
    neg = ~code[WORD_W-1];
    return neg;
  endfunction

  // Offset-binary distance from midscale in steps
  function automatic logic [WORD_W-1:0] offset_mag(input logic [WORD_W-1:0] code);
    logic [WORD_W-1:0] mag;
    logic [WORD_W-1:0] mid;
    mid = WORD_W'(dac_link_pkg::BIPOLAR_MID);
    if (code[WORD_W-1]) begin
      mag = code ^ mid;
    end else begin
      mag = mid - code;
    end
    return mag;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // Sync, edge detect, shift and load decision
  always_comb begin
    logic sclk_rise;
    logic sel_rise;
    logic sel_low;
    logic upd_low;
    logic do_load;
    sclk_rise = 1'b0;
    sel_rise = 1'b0;
    sel_low = 1'b0;
    upd_low = 1'b0;
    do_load = 1'b0;
    st_nxt = st_r;
    // Two-stage sync, third stage for edges
    st_nxt.sclk_s = sync_push(st_r.sclk_s, link.sclk);
    st_nxt.sdata_s = {st_r.sdata_s[0], link.sdata};
    st_nxt.sel_s = sync_push(st_r.sel_s, link.select_n);
    st_nxt.upd_s = sync_push(st_r.upd_s, link.latch_update_n);
    // Edges and levels from settled stages
    sclk_rise = rose_at(st_r.sclk_s);
    sel_rise = rose_at(st_r.sel_s);
    sel_low = ~level_at(st_r.sel_s);
    upd_low = ~level_at(st_r.upd_s);
    // Load strobe lasts one cycle
    st_nxt.load = 1'b0;
    // Shift MSB first on rising clock while selected
    if (sel_low && sclk_rise) begin
      st_nxt.shift = shift_in(st_r.shift, st_r.sdata_s[1]);
      st_nxt.cnt = count_step(st_r.cnt);
    end
    // Count runs across short frames until a word is taken
    if (sel_rise && word_full(st_r.cnt)) begin
      st_nxt.cnt = '0;
      if (upd_low) begin
        do_load = 1'b1;
      end else begin
        st_nxt.pending = 1'b1;
      end
    end else if (st_r.pending && upd_low && !sel_low) begin
      do_load = 1'b1;
      st_nxt.pending = 1'b0;
    end
    // A new frame drops a word still waiting for the pin
    if (sel_low && st_r.pending) begin
      st_nxt.pending = 1'b0;
    end
    // Copy the shifted word into the latch
    if (do_load) begin
      st_nxt.latch = st_r.shift;
      st_nxt.load = 1'b1;
      st_nxt.pending = 1'b0;
    end
    // Offset-binary view of the latch
    st_nxt.neg = offset_neg(st_nxt.latch);
    st_nxt.mag = offset_mag(st_nxt.latch);
    // Reset clears latch and count, sets sync to idle levels, never the shift register
    if (rst) begin
      st_nxt.latch = dac_link_pkg::LATCH_RESET;
      st_nxt.cnt = '0;
      st_nxt.pending = 1'b0;
      st_nxt.load = 1'b0;
      st_nxt.neg = offset_neg(dac_link_pkg::LATCH_RESET);
      st_nxt.mag = offset_mag(dac_link_pkg::LATCH_RESET);
      st_nxt.sclk_s = '0;
      st_nxt.sel_s = '1;
      st_nxt.upd_s = '1;
      st_nxt.sdata_s = '0;
      st_nxt.shift = st_r.shift;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Clock enable freezes everything but reset
  always_ff @(posedge ref_clk) begin
    if (clk_en || rst) begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Every output straight from the state word
  assign dac_code = st_r.latch;
  assign bipolar_neg = st_r.neg;
  assign bipolar_mag = st_r.mag;
  assign load_pulse = st_r.load;
endmodule

// ==== dac_link_pkg.sv ====
// Shared constants for the serial converter word link
package dac_link_pkg;
  localparam int WORD_BITS = 16;
  localparam logic [15:0] LATCH_RESET = 16'h0000;
  localparam logic [15:0] BIPOLAR_MID = 16'h8000;
  localparam int CLK_HZ = 25000000;
  localparam int LINK_PERIOD_NS = 320;
  localparam int REF_PERIOD_NS = 1000000000 / CLK_HZ;
  localparam int HALF_DIV = LINK_PERIOD_NS / REF_PERIOD_NS / 2;
  localparam int BIT_CNT_W = 5;
  localparam int DIV_W = 8;
  localparam logic [7:0] HALF_DIV_CNT = 8'(HALF_DIV - 1);
  localparam logic [4:0] WORD_BITS_CNT = 5'(WORD_BITS);
  localparam int LATCH_UPDATE_N_HOLD = 2;
  localparam logic [7:0] LATCH_UPDATE_N_HOLD_CNT = 8'(LATCH_UPDATE_N_HOLD);
endpackage

// ==== dac_link_if.sv ====
// Interface carrying the serial converter link
`timescale 1ns/1ps
interface dac_link_if;
  logic sclk;
  logic sdata;
  logic select_n;
  logic latch_update_n;
  modport converter (input sclk, input sdata, input select_n, input latch_update_n);
  modport host (output sclk, output sdata, output select_n, output latch_update_n);
endinterface

// ==== dac_word_host.sv ====
// Host end: drives the serial link from a word request
`timescale 1ns/1ps
module dac_word_host #(
  parameter int WORD_W = dac_link_pkg::WORD_BITS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic send_valid,
  input wire logic [WORD_W-1:0] send_word,
  input wire logic use_update,
  output logic send_ready,
  output logic done_pulse,
  dac_link_if.host link
);
  typedef enum logic [2:0] {S_IDLE, S_LOW, S_HIGH, S_END, S_UPD} host_phase_t;

  typedef struct packed {
    host_phase_t phase;
    logic [WORD_W-1:0] data;
    logic [dac_link_pkg::BIT_CNT_W-1:0] bits;
    logic [dac_link_pkg::DIV_W-1:0] div;
    logic use_upd;
    logic sclk;
    logic sdata;
    logic sel_n;
    logic upd_n;
    logic ready;
    logic done;
  } host_state_t;

  host_state_t st_r, st_nxt;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic tick;
    tick = (st_r.div == '0);
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    st_nxt.div = tick ? dac_link_pkg::HALF_DIV_CNT : st_r.div - 1'b1;
    unique case (st_r.phase)
      S_IDLE: begin
        st_nxt.div = dac_link_pkg::HALF_DIV_CNT;
        if (send_valid && st_r.ready) begin
          st_nxt.data = send_word;
          st_nxt.use_upd = use_update;
          st_nxt.bits = '0;
          st_nxt.sel_n = 1'b0;
          st_nxt.upd_n = ~use_update ? 1'b0 : 1'b1;
          st_nxt.sdata = send_word[WORD_W-1];
          st_nxt.ready = 1'b0;
          st_nxt.phase = S_LOW;
        end
      end
      S_LOW: if (tick) begin
        st_nxt.sclk = 1'b1;
        st_nxt.bits = st_r.bits + 1'b1;
        st_nxt.data = {st_r.data[WORD_W-2:0], 1'b0};
        st_nxt.phase = S_HIGH;
      end
      S_HIGH: if (tick) begin
        st_nxt.sclk = 1'b0;
        st_nxt.sdata = st_r.data[WORD_W-1];
        st_nxt.phase = (st_r.bits == dac_link_pkg::WORD_BITS_CNT) ? S_END : S_LOW;
      end
      S_END: if (tick) begin
        st_nxt.sel_n = 1'b1;
        st_nxt.phase = st_r.use_upd ? S_UPD : S_IDLE;
        st_nxt.bits = '0;
        if (!st_r.use_upd) begin
          st_nxt.ready = 1'b1;
          st_nxt.done = 1'b1;
        end
      end
      S_UPD: if (tick) begin
        if (st_r.upd_n) begin
          st_nxt.upd_n = 1'b0;
          st_nxt.bits = dac_link_pkg::WORD_BITS_CNT;
        end else begin
          st_nxt.upd_n = 1'b1;
          st_nxt.ready = 1'b1;
          st_nxt.done = 1'b1;
          st_nxt.phase = S_IDLE;
        end
      end
      default: st_nxt.phase = S_IDLE;
    endcase
    if (rst) begin
      st_nxt.phase = S_IDLE;
      st_nxt.data = '0;
      st_nxt.bits = '0;
      st_nxt.div = '0;
      st_nxt.use_upd = 1'b0;
      st_nxt.sclk = 1'b0;
      st_nxt.sdata = 1'b0;
      st_nxt.sel_n = 1'b1;
      st_nxt.upd_n = 1'b1;
      st_nxt.ready = 1'b1;
      st_nxt.done = 1'b0;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (clk_en || rst) begin
      st_r <= st_nxt;
    end
  end

  // Link pins from flip-flops
  assign link.sclk = st_r.sclk;
  assign link.sdata = st_r.sdata;
  assign link.select_n = st_r.sel_n;
  assign link.latch_update_n = st_r.upd_n;
  assign send_ready = st_r.ready;
  assign done_pulse = st_r.done;
endmodule

// ==== dac_link_checker.sv ====
// Checker for the host-to-converter serial link and the converter latch
`timescale 1ns/1ps
module dac_link_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic select_n,
  input wire logic latch_update_n,
  input wire logic [15:0] dac_code,
  input wire logic bipolar_neg,
  input wire logic load_pulse
);
  // ------------------------------
  // Rising clock count in a frame
  // ------------------------------
  logic [4:0] cnt_r;
  logic sclk_q_r;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Counts rising serial clock edges while selected
  always_ff @(posedge ref_clk) begin
    sclk_q_r <= sclk;
    if (rst || select_n) begin
      cnt_r <= 5'h00;
    end else if (sclk && !sclk_q_r) begin
      cnt_r <= cnt_r + 5'h01;
    end
  end
  a_idle_clock_low: assert property (select_n |-> !sclk)
    else $error("serial clock high outside a frame");
  a_update_held: assert property (!select_n && $past(!select_n) |-> $stable(latch_update_n))
    else $error("update pin moved while shifting");
  a_half_period: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("serial clock high phase not four cycles");
  a_data_steady: assert property ($rose(sclk) |-> $stable(sdata))
    else $error("data changed at rising serial clock");
  a_frame_sixteen: assert property ($rose(select_n) |-> cnt_r == 5'h10)
    else $error("frame did not carry sixteen bits");
  a_code_on_load: assert property ($changed(dac_code) |-> load_pulse)
    else $error("latch changed without a load");
  a_load_after_select: assert property (load_pulse |-> $past(select_n, 2) && !$past(load_pulse))
    else $error("load without select high");
  a_bipolar_sign: assert property (bipolar_neg == !dac_code[15])
    else $error("bipolar sign wrong");
endmodule

// ==== dac_serial_word_loader_tb.sv ====
// Testbench joining host and converter ends over the serial link
`timescale 1ns/1ps
module dac_serial_word_loader_tb;
  logic ref_clk, rst, send_valid, use_update, send_ready, done_pulse, lp, lp2, neg, neg2;
  logic [15:0] send_word, code, code2, mag, mag2;
  int failures = 0;
  int compares = 0;
  int loads2 = 0;
  dac_link_if lk();
  dac_link_if lk2();
  dac_word_host dac_word_host_inst(.ref_clk(ref_clk), .rst(rst), .clk_en(1'b1),
    .send_valid(send_valid), .send_word(send_word), .use_update(use_update),
    .send_ready(send_ready), .done_pulse(done_pulse), .link(lk));
  dac_word_loader dac_word_loader_inst(.ref_clk(ref_clk), .rst(rst), .clk_en(1'b1),
    .link(lk), .dac_code(code), .bipolar_neg(neg), .bipolar_mag(mag), .load_pulse(lp));
  dac_word_loader dac_word_loader_inst2(.ref_clk(ref_clk), .rst(rst), .clk_en(1'b1),
    .link(lk2), .dac_code(code2), .bipolar_neg(neg2), .bipolar_mag(mag2), .load_pulse(lp2));
  dac_link_checker dac_link_checker_inst(.ref_clk(ref_clk), .rst(rst), .sclk(lk.sclk),
    .sdata(lk.sdata), .select_n(lk.select_n), .latch_update_n(lk.latch_update_n),
    .dac_code(code), .bipolar_neg(neg), .load_pulse(lp));
  // Counts latch loads on the bench-driven link
  always @(posedge ref_clk) begin
    if (lp2 === 1'b1) loads2++;
  end
  // -----------------
  // Clock and tasks
  // -----------------
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task tally_and_finish();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Host request, then latch and bipolar outputs
  task send(input logic [15:0] w, input logic u);
    int n;
    n = 0;
    send_word = w;
    use_update = u;
    send_valid = 1'b1;
    cyc(1);
    send_valid = 1'b0;
    while (done_pulse !== 1'b1 && n < 400) begin
      cyc(1);
      n++;
    end
    if (n == 400) begin
      failures++;
      tally_and_finish();
    end
    cyc(8);
    chk("code", w, code);
    chk("mag", w[15] ? w - 16'h8000 : 16'h8000 - w, mag);
    chk("neg", {15'h0000, ~w[15]}, {15'h0000, neg});
    chk("ready", 16'h0001, {15'h0000, send_ready});
  endtask
  // Bench-made frame on the second link, MSB first
  task shift(input int n, input logic [31:0] v, input logic u);
    lk2.latch_update_n = u;
    lk2.select_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      lk2.sdata = v[i];
      cyc(4);
      lk2.sclk = 1'b1;
      cyc(4);
      lk2.sclk = 1'b0;
    end
    cyc(4);
    lk2.select_n = 1'b1;
    lk2.sdata = ~lk2.sdata;
    cyc(8);
  endtask
  // -----------------
  // Test sequence
  // -----------------
  initial begin
    rst = 1'b1;
    send_valid = 1'b0;
    send_word = 16'h0000;
    use_update = 1'b0;
    {lk2.sclk, lk2.sdata, lk2.select_n, lk2.latch_update_n} = 4'h3;
    cyc(3);
    rst = 1'b0;
    cyc(3);
    chk("reset code", 16'h0000, code);
    chk("reset code b", 16'h0000, code2);
    $display("test reset done");
    send(16'ha5c3, 1'b0);
    send(16'h0001, 1'b1);
    send(16'h8000, 1'b0);
    send(16'h5a00, 1'b0);
    $display("test host link done");
    shift(16, 32'h0000_1234, 1'b0);
    chk("full word", 16'h1234, code2);
    chk("mag b", 16'h6dcc, mag2);
    chk("neg b", 16'h0001, {15'h0000, neg2});
    shift(20, 32'h0005_abcd, 1'b0);
    chk("long frame", 16'habcd, code2);
    shift(8, 32'h0000_0077, 1'b0);
    chk("short frame", 16'habcd, code2);
    shift(8, 32'h0000_0055, 1'b0);
    chk("short pair", 16'h7755, code2);
    repeat (6) begin
      lk2.sclk = ~lk2.sclk;
      lk2.sdata = ~lk2.sdata;
      cyc(4);
    end
    chk("idle clock", 16'h7755, code2);
    shift(16, 32'h0000_beef, 1'b1);
    chk("update held", 16'h7755, code2);
    lk2.latch_update_n = 1'b0;
    cyc(4);
    lk2.latch_update_n = 1'b1;
    cyc(8);
    chk("update pin", 16'hbeef, code2);
    chk("loads b", 16'h0004, 16'(loads2));
    $display("test bench link done");
    tally_and_finish();
  end
  // Watchdog against a hung handshake
  initial begin
    #200000;
    failures++;
    tally_and_finish();
  end
endmodule
